// ==== bpc_pkg.sv ====
package bpc_pkg;
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;

    localparam int NUM_PROT = 10;
    localparam int NUM_RED = 4;
    localparam int NUM_THR = 10;
    localparam int NUM_FILT = 13;
    localparam int DLY_W = 16;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PRECHG = 8'h08;
    localparam logic [7:0] ADDR_THR_BASE = 8'h40;
    localparam logic [7:0] ADDR_DLY_BASE = 8'h80;

    localparam int CTRL_PROT_EN_LSB = 0;
    localparam int CTRL_RED_EN_LSB = 10;
    localparam int CTRL_EXT_EN_BIT = 14;
    localparam int CTRL_RST_PROT_BIT = 15;

    localparam int STAT_PROT_LSB = 0;
    localparam int STAT_RED_LSB = 10;
    localparam int STAT_CONTACTOR_BIT = 14;
    localparam int STAT_PRECHG_BIT = 15;
    localparam int STAT_POWRED_BIT = 16;
    localparam int STAT_INTERLOCK_BIT = 17;
    localparam int STAT_PERMIT_BIT = 18;

    localparam logic [9:0] PROT_EN_RST = 10'h3FF;
    localparam logic [3:0] RED_EN_RST = 4'hF;
    localparam logic [31:0] THR_RST_BELOW = 32'h0000_0000;
    localparam logic [31:0] THR_RST_ABOVE = 32'hFFFF_FFFF;
    localparam logic [9:0] THR_BELOW_MASK = 10'h041;
    localparam logic [31:0] DLY_RST = 32'h0000_0000;
    localparam logic [31:0] PRECHG_RST = 32'h0000_0064;

    typedef struct packed {
        logic [15:0] min_cell_v;
        logic [15:0] max_cell_v;
        logic        cell_v_valid;
        logic [15:0] dis_current;
        logic [15:0] chg_current;
        logic [15:0] max_mod_temp;
        logic        mod_temp_valid;
        logic [15:0] max_cell_temp;
        logic        cell_temp_valid;
        logic        cell_comm_ok;
    } bpc_meas_t;

    typedef enum logic [1:0] {CT_OPEN, CT_PRECHG, CT_CLOSED} bpc_ct_state_t;
    typedef enum logic {OVR_HOLD, OVR_RUN} bpc_ovr_state_t;

    typedef struct packed {
        logic             active;
        logic [DLY_W-1:0] cnt;
    } bpc_filt_state_t;
endpackage : bpc_pkg

// ==== bpc_sync.sv ====
module bpc_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } bpc_sync_state_t;

    bpc_sync_state_t s_reg;
    bpc_sync_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.meta = async_i;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_o = s_reg.sync;
endmodule : bpc_sync

// ==== bpc_filter.sv ====
module bpc_filter #(
    parameter logic INIT_ACTIVE = 1'b0
) (
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     tick_i,
    input  wire logic                     act_cond_i,
    input  wire logic                     deact_cond_i,
    input  wire logic [bpc_pkg::DLY_W-1:0] act_delay_i,
    input  wire logic [bpc_pkg::DLY_W-1:0] deact_delay_i,
    input  wire logic                     fast_clear_i,
    output logic                          active_o
);
    bpc_pkg::bpc_filt_state_t s_reg;
    bpc_pkg::bpc_filt_state_t s_next;

    // sampled on ticks only; glitches between ticks ignored
    always_comb begin
        s_next = s_reg;
        if (tick_i) begin
            if (!s_reg.active) begin
                if (act_cond_i) begin
                    if (s_reg.cnt >= act_delay_i) begin
                        s_next.active = 1'b1;
                        s_next.cnt = '0;
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end else begin
                    s_next.cnt = '0;
                end
            end else if (fast_clear_i) begin
                s_next.active = 1'b0;
                s_next.cnt = '0;
            end else if (deact_cond_i) begin
                if (s_reg.cnt >= deact_delay_i) begin
                    s_next.active = 1'b0;
                    s_next.cnt = '0;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
            end else begin
                s_next.cnt = '0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg.active <= INIT_ACTIVE;
            s_reg.cnt <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign active_o = s_reg.active;
endmodule : bpc_filter

// ==== bpc_top.sv ====
// Overview of operation
// [RULE_01] interlock output follows charger presence, nothing else.
// [RULE_02] contactor opens while any enabled protection is active.
// [RULE_03] under-voltage trips when lowest cell is below its threshold.
// [RULE_04] over-voltage trips when highest cell is above its threshold.
// [RULE_05] discharge over-current trips above its threshold.
// [RULE_06] charge over-current trips above its threshold, opening contactor.
// [RULE_07] module over-heat trips when internal temperature exceeds threshold.
// [RULE_08] no-cell-communication trips while cell data is unavailable.
// [RULE_09] insulation fault trips while leakage input is active.
// [RULE_10] cell over-heat trips when external temperature exceeds threshold.
// [RULE_11] missing current sensor trips when sensor absent or miswired.
// [RULE_12] charger-connected protection opens contactor during charging.
// [RULE_13] ten protection enables, all set after reset, each clearable.
// [RULE_14] separate deactivation threshold gives hysteresis per threshold.
// [RULE_15] activation and deactivation delays, except charger-connected.
// [RULE_16] cell-based protections activate only on valid measurements.
// [RULE_17] no-comm starts active at power-up, clears at once on comm.
// [RULE_18] pre-charge bypass pulses for configured time before each closing.
// [RULE_19] external override holds contactor off until CAN activation.
// [RULE_20] reset-on-protection needs new activation after any trip.
// [RULE_21] power reduction output while any enabled reduction is active.
// [RULE_22] reductions have hysteresis, delays, enables set after reset.
// [RULE_23] conditions evaluated per timebase tick; delays count ticks.
module bpc_top #(
    parameter int TICK_CYCLES = bpc_pkg::TICK_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire bpc_pkg::bpc_meas_t meas_i,
    input  wire logic              leakage_sense_in_i,
    input  wire logic              charger_connected_i,
    input  wire logic              current_sensor_ok_i,
    input  wire logic              can_activate_i,
    input  wire logic              can_deactivate_i,
    output logic                   main_contactor_out_o,
    output logic                   precharge_bypass_out_o,
    output logic                   power_reduction_out_o,
    output logic                   charging_interlock_out_o
);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [9:0]        prot_en;
        logic [3:0]        red_en;
        logic              ext_en;
        logic              rst_on_prot;
        logic [9:0][31:0]  thr;
        logic [12:0][31:0] dly;
        logic [31:0]       prechg_dur;
        logic              ack;
        logic [31:0]       rdata;
        logic [31:0]       tick_cnt;
        logic              tick;
        logic              prot_q;
        bpc_pkg::bpc_ct_state_t  ct_state;
        bpc_pkg::bpc_ovr_state_t ovr_state;
        logic [31:0]       pc_cnt;
        logic              contactor;
        logic              precharge;
        logic              powred;
        logic              interlock;
    } bpc_top_state_t;

    bpc_top_state_t s_reg;
    bpc_top_state_t s_next;

    logic [2:0]  pin_sync;
    logic        leak_s;
    logic        chg_s;
    logic        sens_s;
    logic [12:0] act_c;
    logic [12:0] deact_c;
    logic [12:0] filt_out;
    logic [9:0]  prot_act;
    logic [3:0]  red_act;
    logic        any_prot;
    logic        permit;
    logic        want;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // {act, deact}; word holds act low, deact high
    function automatic logic [1:0] hyst(input logic [15:0] v,
                                        input logic [31:0] thr,
                                        input logic        below,
                                        input logic        valid);
        logic a;
        logic d;
        a = below ? (v < thr[15:0]) : (v > thr[15:0]);
        d = below ? (v >= thr[31:16]) : (v <= thr[31:16]);
        return {a & valid, d & valid};
    endfunction : hyst

    function automatic logic [7:0] word_idx(input logic [7:0] adr,
                                            input logic [7:0] base);
        logic [7:0] diff;
        diff = adr - base;
        return {2'b00, diff[7:2]};
    endfunction : word_idx

    bpc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .async_i  ({leakage_sense_in_i, charger_connected_i, current_sensor_ok_i}),
        .sync_o   (pin_sync)
    );

    assign leak_s = pin_sync[2];
    assign chg_s = pin_sync[1];
    assign sens_s = pin_sync[0];

    // filters 0..8 protections, 9..12 reductions
    assign {act_c[0], deact_c[0]} =
        hyst(meas_i.min_cell_v, s_reg.thr[0], 1'b1, meas_i.cell_v_valid); // [RULE_03] [RULE_16]
    assign {act_c[1], deact_c[1]} =
        hyst(meas_i.max_cell_v, s_reg.thr[1], 1'b0, meas_i.cell_v_valid); // [RULE_04] [RULE_16]
    assign {act_c[2], deact_c[2]} =
        hyst(meas_i.dis_current, s_reg.thr[2], 1'b0, 1'b1); // [RULE_05] [RULE_14]
    assign {act_c[3], deact_c[3]} =
        hyst(meas_i.chg_current, s_reg.thr[3], 1'b0, 1'b1); // [RULE_06] [RULE_14]
    assign {act_c[4], deact_c[4]} =
        hyst(meas_i.max_mod_temp, s_reg.thr[4], 1'b0, meas_i.mod_temp_valid); // [RULE_07]
    assign act_c[5] = !meas_i.cell_comm_ok; // [RULE_08]
    assign deact_c[5] = meas_i.cell_comm_ok;
    assign act_c[6] = leak_s; // [RULE_09]
    assign deact_c[6] = !leak_s;
    assign {act_c[7], deact_c[7]} =
        hyst(meas_i.max_cell_temp, s_reg.thr[5], 1'b0, meas_i.cell_temp_valid); // [RULE_10]
    assign act_c[8] = !sens_s; // [RULE_11]
    assign deact_c[8] = sens_s;
    assign {act_c[9], deact_c[9]} =
        hyst(meas_i.min_cell_v, s_reg.thr[6], 1'b1, meas_i.cell_v_valid); // [RULE_22]
    assign {act_c[10], deact_c[10]} =
        hyst(meas_i.dis_current, s_reg.thr[7], 1'b0, 1'b1); // [RULE_22]
    assign {act_c[11], deact_c[11]} =
        hyst(meas_i.max_mod_temp, s_reg.thr[8], 1'b0, meas_i.mod_temp_valid); // [RULE_22]
    assign {act_c[12], deact_c[12]} =
        hyst(meas_i.max_cell_temp, s_reg.thr[9], 1'b0, meas_i.cell_temp_valid); // [RULE_22]

    for (genvar i = 0; i < bpc_pkg::NUM_FILT; i++) begin : g_filt
        bpc_filter #(
            .INIT_ACTIVE (i == 5) // [RULE_17]
        ) u_filt (
            .clock_i       (clock_i),
            .arst_n_i      (arst_n_i),
            .tick_i        (s_reg.tick), // [RULE_23]
            .act_cond_i    (act_c[i]),
            .deact_cond_i  (deact_c[i]),
            .act_delay_i   (s_reg.dly[i][15:0]), // [RULE_15]
            .deact_delay_i (s_reg.dly[i][31:16]),
            .fast_clear_i  ((i == 5) && meas_i.cell_comm_ok), // [RULE_17]
            .active_o      (filt_out[i])
        );
    end

    // charger protection: no delay
    assign prot_act = {chg_s, filt_out[8:0]}; // [RULE_12] [RULE_15]
    assign red_act = filt_out[12:9];
    assign any_prot = |(prot_act & s_reg.prot_en); // [RULE_13]
    assign permit = !s_reg.ext_en || (s_reg.ovr_state == bpc_pkg::OVR_RUN); // [RULE_19]
    assign want = permit && !any_prot; // [RULE_02]

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[bpc_pkg::CTRL_PROT_EN_LSB +: 10] = s_reg.prot_en;
        ctrl_word[bpc_pkg::CTRL_RED_EN_LSB +: 4] = s_reg.red_en;
        ctrl_word[bpc_pkg::CTRL_EXT_EN_BIT] = s_reg.ext_en;
        ctrl_word[bpc_pkg::CTRL_RST_PROT_BIT] = s_reg.rst_on_prot;
        stat_word = 32'h0000_0000;
        stat_word[bpc_pkg::STAT_PROT_LSB +: 10] = prot_act;
        stat_word[bpc_pkg::STAT_RED_LSB +: 4] = red_act;
        stat_word[bpc_pkg::STAT_CONTACTOR_BIT] = s_reg.contactor;
        stat_word[bpc_pkg::STAT_PRECHG_BIT] = s_reg.precharge;
        stat_word[bpc_pkg::STAT_POWRED_BIT] = s_reg.powred;
        stat_word[bpc_pkg::STAT_INTERLOCK_BIT] = s_reg.interlock;
        stat_word[bpc_pkg::STAT_PERMIT_BIT] = permit;
    end

    always_comb begin
        logic [31:0] w;
        logic [7:0]  idx;
        w = 32'h0000_0000;
        idx = 8'h00;
        s_next = s_reg;
        s_next.ack = 1'b0;

        // register slave, one wait state, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.rdata = 32'h0000_0000;
            if (wb_adr_i == bpc_pkg::ADDR_CTRL) begin
                s_next.rdata = ctrl_word;
                if (wb_we_i) begin
                    w = merge(ctrl_word, wb_dat_i, wb_sel_i);
                    s_next.prot_en = w[bpc_pkg::CTRL_PROT_EN_LSB +: 10]; // [RULE_13]
                    s_next.red_en = w[bpc_pkg::CTRL_RED_EN_LSB +: 4]; // [RULE_22]
                    s_next.ext_en = w[bpc_pkg::CTRL_EXT_EN_BIT];
                    s_next.rst_on_prot = w[bpc_pkg::CTRL_RST_PROT_BIT];
                end
            end else if (wb_adr_i == bpc_pkg::ADDR_STATUS) begin
                s_next.rdata = stat_word;
            end else if (wb_adr_i == bpc_pkg::ADDR_PRECHG) begin
                s_next.rdata = s_reg.prechg_dur;
                if (wb_we_i) begin
                    s_next.prechg_dur = merge(s_reg.prechg_dur, wb_dat_i, wb_sel_i);
                end
            end else if ((wb_adr_i >= bpc_pkg::ADDR_THR_BASE) &&
                         (wb_adr_i < 8'(bpc_pkg::ADDR_THR_BASE + 4 * bpc_pkg::NUM_THR)) &&
                         (wb_adr_i[1:0] == 2'b00)) begin
                idx = word_idx(wb_adr_i, bpc_pkg::ADDR_THR_BASE);
                s_next.rdata = s_reg.thr[idx[3:0]];
                if (wb_we_i) begin
                    s_next.thr[idx[3:0]] = merge(s_reg.thr[idx[3:0]], wb_dat_i, wb_sel_i); // [RULE_14]
                end
            end else if ((wb_adr_i >= bpc_pkg::ADDR_DLY_BASE) &&
                         (wb_adr_i < 8'(bpc_pkg::ADDR_DLY_BASE + 4 * bpc_pkg::NUM_FILT)) &&
                         (wb_adr_i[1:0] == 2'b00)) begin
                idx = word_idx(wb_adr_i, bpc_pkg::ADDR_DLY_BASE);
                s_next.rdata = s_reg.dly[idx[3:0]];
                if (wb_we_i) begin
                    s_next.dly[idx[3:0]] = merge(s_reg.dly[idx[3:0]], wb_dat_i, wb_sel_i); // [RULE_15]
                end
            end
        end

        // timebase
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt >= TICK_LAST) begin
            s_next.tick_cnt = 32'h0000_0000;
            s_next.tick = 1'b1; // [RULE_23]
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 32'h0000_0001;
        end

        // override: deactivation and trips beat a same-cycle activation
        s_next.prot_q = any_prot;
        if (!s_reg.ext_en) begin
            s_next.ovr_state = bpc_pkg::OVR_HOLD;
        end else if (can_deactivate_i) begin
            s_next.ovr_state = bpc_pkg::OVR_HOLD; // [RULE_19]
        end else if (s_reg.rst_on_prot && any_prot && !s_reg.prot_q) begin
            s_next.ovr_state = bpc_pkg::OVR_HOLD; // [RULE_20]
        end else if (can_activate_i) begin
            s_next.ovr_state = bpc_pkg::OVR_RUN; // [RULE_19] [RULE_20]
        end

        // closes only after the bypass period
        case (s_reg.ct_state)
            bpc_pkg::CT_OPEN: begin
                s_next.pc_cnt = 32'h0000_0000;
                if (want) begin
                    s_next.ct_state = bpc_pkg::CT_PRECHG; // [RULE_18]
                end
            end
            bpc_pkg::CT_PRECHG: begin
                if (!want) begin
                    s_next.ct_state = bpc_pkg::CT_OPEN; // [RULE_02]
                end else if (s_reg.tick) begin
                    if (s_reg.pc_cnt >= s_reg.prechg_dur) begin
                        s_next.ct_state = bpc_pkg::CT_CLOSED; // [RULE_18] [RULE_23]
                    end else begin
                        s_next.pc_cnt = s_reg.pc_cnt + 32'h0000_0001;
                    end
                end
            end
            bpc_pkg::CT_CLOSED: begin
                if (!want) begin
                    s_next.ct_state = bpc_pkg::CT_OPEN; // [RULE_02]
                end
            end
            default: begin
                s_next.ct_state = bpc_pkg::CT_OPEN;
            end
        endcase

        s_next.contactor = (s_next.ct_state == bpc_pkg::CT_CLOSED); // [RULE_02]
        s_next.precharge = (s_next.ct_state == bpc_pkg::CT_PRECHG); // [RULE_18]
        s_next.powred = |(red_act & s_reg.red_en); // [RULE_21]
        s_next.interlock = chg_s; // [RULE_01]
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            s_reg.prot_en <= bpc_pkg::PROT_EN_RST; // [RULE_13]
            s_reg.red_en <= bpc_pkg::RED_EN_RST; // [RULE_22]
            for (int t = 0; t < bpc_pkg::NUM_THR; t++) begin
                s_reg.thr[t] <= bpc_pkg::THR_BELOW_MASK[t] ? bpc_pkg::THR_RST_BELOW
                                                           : bpc_pkg::THR_RST_ABOVE;
            end
            for (int f = 0; f < bpc_pkg::NUM_FILT; f++) begin
                s_reg.dly[f] <= bpc_pkg::DLY_RST;
            end
            s_reg.prechg_dur <= bpc_pkg::PRECHG_RST;
            s_reg.ct_state <= bpc_pkg::CT_OPEN;
            s_reg.ovr_state <= bpc_pkg::OVR_HOLD;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign main_contactor_out_o = s_reg.contactor;
    assign precharge_bypass_out_o = s_reg.precharge;
    assign power_reduction_out_o = s_reg.powred;
    assign charging_interlock_out_o = s_reg.interlock;
endmodule : bpc_top

// ==== bpc_top_sva.sv ====
module bpc_top_sva #(
    parameter int TICK_CYCLES = bpc_pkg::TICK_CYCLES
) (
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        charger_connected_i,
    input wire logic        main_contactor_out_o,
    input wire logic        precharge_bypass_out_o,
    input wire logic        power_reduction_out_o,
    input wire logic        charging_interlock_out_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    logic [31:0] up_cnt_reg, up_cnt_next;
    // saturates, never wraps
    always_comb up_cnt_next = (&up_cnt_reg) ? up_cnt_reg : up_cnt_reg + 32'h1;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) up_cnt_reg <= '0;
        else up_cnt_reg <= up_cnt_next;
    end
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_ilk_follow: assert property (up_cnt_reg > 32'h3
        |-> charging_interlock_out_o == $past(charger_connected_i, 3))
        else $error("interlock mismatch");
    a_no_overlap: assert property (!(main_contactor_out_o && precharge_bypass_out_o))
        else $error("bypass with contactor");
    a_close_pre: assert property ($rose(main_contactor_out_o) |-> $past(precharge_bypass_out_o))
        else $error("close without bypass");
    a_pre_late: assert property (up_cnt_reg < 32'(TICK_CYCLES) |-> !precharge_bypass_out_o)
        else $error("early bypass");
    a_main_late: assert property (up_cnt_reg < 32'(2 * TICK_CYCLES) |-> !main_contactor_out_o)
        else $error("early close");
    c_close: cover property ($rose(main_contactor_out_o));
    c_red: cover property ($rose(power_reduction_out_o));
    c_ilk: cover property ($rose(charging_interlock_out_o));
endmodule : bpc_top_sva
bind bpc_top bpc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// ==== bpc_can_host_model.sv ====
module bpc_can_host_model (
    input  wire logic clock_i,
    input  wire logic arst_n_i,
    input  wire logic send_act_i,
    input  wire logic send_deact_i,
    output logic      can_activate_o,
    output logic      can_deactivate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulses on every other cycle while a request is held
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            can_activate_o <= 1'b0;
            can_deactivate_o <= 1'b0;
        end else begin
            can_activate_o <= send_act_i && !can_activate_o;
            can_deactivate_o <= send_deact_i && !can_deactivate_o;
        end
    end
endmodule : bpc_can_host_model

// ==== tb.sv ====
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 8;
    logic clock_i, arst_n_i, cyc, we, ack, main, pre, pred, ilk, leak, chg, sens, ra, rq, ca, cq;
    logic [7:0] adr;
    logic [31:0] wdat, rd, rdv;
    bpc_pkg::bpc_meas_t meas;
    int err_total, checks_done;
    bpc_top #(.TICK_CYCLES(T)) u_dut (.clock_i, .arst_n_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd),
        .wb_ack_o(ack), .meas_i(meas), .leakage_sense_in_i(leak), .charger_connected_i(chg),
        .current_sensor_ok_i(sens), .can_activate_i(ca), .can_deactivate_i(cq),
        .main_contactor_out_o(main), .precharge_bypass_out_o(pre),
        .power_reduction_out_o(pred), .charging_interlock_out_o(ilk));
    bpc_can_host_model u_host (.clock_i, .arst_n_i, .send_act_i(ra), .send_deact_i(rq),
        .can_activate_o(ca), .can_deactivate_o(cq));
    task automatic complete_run();
        $display("errors=%0d checks=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clock_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdv = rd;
        cyc <= 1'b0;
        if (n >= 50) begin
            err_total++;
            complete_run();
        end
    endtask : wb
    task automatic wait_out(input int w, input logic v);
        checks_done++;
        for (int n = 0; n < 4000; n++) begin
            @(negedge clock_i);
            if ((w == 0 ? main : w == 1 ? pred : pre) === v) return;
        end
        $display("[FAIL] t=%0t got=%h exp=%h", $time, ~v, v);
        err_total++;
        complete_run();
    endtask : wait_out
    task automatic fault(input int k, input logic on);
        @(posedge clock_i);
        case (k)
            0: meas.min_cell_v <= on ? 16'h0032 : 16'h0BB8;
            1: meas.max_cell_v <= on ? 16'h1004 : 16'h0CE4;
            2: meas.dis_current <= on ? 16'h0200 : 16'h000A;
            3: meas.chg_current <= on ? 16'h0200 : 16'h000A;
            4: meas.max_mod_temp <= on ? 16'h0200 : 16'h0019;
            5: meas.cell_comm_ok <= !on;
            6: leak <= on;
            7: meas.max_cell_temp <= on ? 16'h0200 : 16'h0019;
            8: sens <= !on;
            default: chg <= on;
        endcase
    endtask : fault
    task automatic send(input logic a);
        @(posedge clock_i);
        ra <= a;
        rq <= !a;
        @(posedge clock_i);
        ra <= 1'b0;
        rq <= 1'b0;
    endtask : send
    task automatic t_regs_powerup();
        int n;
        wb(1'b0, 8'h00, 32'h0);
        `CHK(rdv, 32'h0000_3FFF)
        wb(1'b0, 8'h08, 32'h0);
        `CHK(rdv, bpc_pkg::PRECHG_RST)
        wb(1'b1, 8'h3C, 32'h1234_5678);
        wb(1'b0, 8'h3C, 32'h0);
        `CHK(rdv, 32'h0)
        repeat (3 * T) @(negedge clock_i);
        `CHK(main, 1'b0)
        fault(5, 1'b0);
        wait_out(2, 1'b1);
        for (n = 0; pre === 1'b1 && n < 2000; n++) @(negedge clock_i);
        `CHK(n >= 101 * T - 3 && n <= 101 * T, 1'b1)
        `CHK(main, 1'b1)
    endtask : t_regs_powerup
    task automatic t_prot();
        logic [31:0] thr [6] = '{32'h0078_0064, 32'h0F3C_0FA0, 32'h0190_01F4,
                                 32'h0190_01F4, 32'h0190_01F4, 32'h0190_01F4};
        for (int i = 0; i < 6; i++) wb(1'b1, 8'h40 + 8'(4 * i), thr[i]);
        wb(1'b1, 8'h08, 32'h0000_0001);
        for (int k = 0; k < 10; k++) begin
            fault(k, 1'b1);
            wait_out(0, 1'b0);
            wb(1'b0, 8'h04, 32'h0);
            `CHK(rdv[k], 1'b1)
            `CHK(ilk, k == 9)
            fault(k, 1'b0);
            wait_out(0, 1'b1);
        end
    endtask : t_prot
    task automatic t_edge();
        wb(1'b1, 8'h80, 32'h0000_0003);
        fault(0, 1'b1);
        repeat (2 * T) @(negedge clock_i);
        `CHK(main, 1'b1)
        wait_out(0, 1'b0);
        @(posedge clock_i) meas.min_cell_v <= 16'h006E;
        repeat (6 * T) @(negedge clock_i);
        `CHK(main, 1'b0)
        fault(0, 1'b0);
        wait_out(0, 1'b1);
        @(posedge clock_i) meas.cell_v_valid <= 1'b0;
        fault(0, 1'b1);
        repeat (8 * T) @(negedge clock_i);
        `CHK(main, 1'b1)
        fault(0, 1'b0);
        meas.cell_v_valid <= 1'b1;
        wb(1'b1, 8'h00, 32'h0000_3FBF);
        fault(6, 1'b1);
        repeat (4 * T) @(negedge clock_i);
        `CHK(main, 1'b1)
        fault(6, 1'b0);
        repeat (2 * T) @(negedge clock_i);
        wb(1'b1, 8'h00, 32'h0000_3FFF);
    endtask : t_edge
    task automatic t_red_ext();
        wb(1'b1, 8'h58, 32'h0B86_0B54);
        meas.min_cell_v <= 16'h0AF0;
        wait_out(1, 1'b1);
        wb(1'b1, 8'h00, 32'h0000_3BFF);
        wait_out(1, 1'b0);
        wb(1'b1, 8'h00, 32'h0000_7FFF);
        wait_out(1, 1'b1);
        wait_out(0, 1'b0);
        fault(0, 1'b0);
        wait_out(1, 1'b0);
        send(1'b1);
        wait_out(0, 1'b1);
        send(1'b0);
        wait_out(0, 1'b0);
        wb(1'b1, 8'h00, 32'h0000_FFFF);
        send(1'b1);
        wait_out(0, 1'b1);
        fault(2, 1'b1);
        wait_out(0, 1'b0);
        fault(2, 1'b0);
        repeat (6 * T) @(negedge clock_i);
        `CHK(main, 1'b0)
        send(1'b1);
        wait_out(0, 1'b1);
    endtask : t_red_ext
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        {arst_n_i, cyc, we, leak, chg, ra, rq, adr, wdat, err_total, checks_done} = '0;
        sens = 1'b1;
        meas = '{16'h0BB8, 16'h0CE4, 1'b1, 16'h000A, 16'h000A, 16'h0019, 1'b1, 16'h0019, 1'b1, 1'b0};
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'b1;
        t_regs_powerup();
        t_prot();
        t_edge();
        t_red_ext();
        complete_run();
    end
endmodule : tb
